// ### imms_selector.sv
// Notes on behaviour
// R1: NMI accepted always, except in reset or hardware standby.
// R2: Each source has an enable bit; disabled sources never request.
// R3: Two mode bits choose control mode 0, 1, 2 or 3.
// R4: Mode 0: mask flag 0 passes all; 1 passes only NMI.
// R5: Mode 1: three-level masking by mask flag and user mask bit.
// R6: Modes 0/1 with flag 0: control level 1 beats level 0.
// R7: First-stage gating active in modes 0, 1, 3; mode 2 passes all.
// R8: Mode 2 masks by 3-bit level only; control level ignored.
// R9: Mode 3: mode-1 gating first, then 8-level priority masking.
// R10: 8-level stage only in modes 2 and 3; else passes all.
// R11: Highest level wins, only if strictly above CPU mask level.
// R12: Ties go to the lowest source index, the fixed default order; mode 3 here ranks control level 1 first at equal level.
// R13: Unselected requests stay pending until selected later.
// R14: Result recomputed every clock from current inputs and state.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`include "imms_defines.svh"

module imms_selector
   import imms_pkg::*;
#(
   parameter int N_SRC = 8
)
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic [N_SRC-1:0] src_req_in,
   input wire logic nmi_req_in,
   input wire logic standby_in,
   input wire imms_cpu_mask_t cpu_mask_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic irq_req_out,
   output logic [7:0] irq_src_out,
   output logic [2:0] irq_prio_out,
   output logic nmi_out,
   output logic irq_out
);

   localparam int NS = `IMMS_SYNC_STAGES;

   // Pin synchronisers: src bits plus NMI and standby
   localparam int NP = N_SRC + 2;
   logic [NP-1:0] sync_r [NS];
   logic [NP-1:0] pin_q_r;
   logic [NP-1:0] pin_q_nxt;
   logic [N_SRC-1:0] req_q;
   logic nmi_q;
   logic stby_q;

   imms_mode_t mode_r, mode_nxt;
   logic [N_SRC-1:0] enable_r, enable_nxt;
   logic [N_SRC-1:0] ctl_r, ctl_nxt;
   logic [31:0] prio_r, prio_nxt;
   logic [1:0] status_r, status_nxt;
   logic [1:0] imask_r, imask_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wait_r, wait_nxt;
   imms_sel_t out_r, out_nxt;
   logic nmi_r, nmi_nxt;
   logic irq_r, irq_nxt;
   logic [N_SRC-1:0] cand;
   logic [N_SRC-1:0] ctl_d_r;
   logic wr_go;
   logic rd_go;
   logic [1:0] events;

   function automatic logic [2:0] src_prio(input logic [31:0] p,
                                           input int i);
      src_prio = p[i*`IMMS_PRIO_STRIDE +: 3];
   endfunction

   // First-stage gate for one source
   function automatic logic stage1_pass(input imms_mode_t m,
                                        input imms_cpu_mask_t c,
                                        input logic lvl1);
      logic ok;
      ok = 1'b0;
      unique case (m)
         IMMS_MODE0: ok = !c.mask_flag; // [R4]
         IMMS_MODE2: ok = 1'b1; // [R7]
         IMMS_MODE1, IMMS_MODE3: // [R5] [R9]
            ok = !c.mask_flag || (lvl1 && !c.user_mask_bit);
      endcase
      stage1_pass = ok;
   endfunction

   assign req_q = pin_q_r[N_SRC-1:0];
   assign nmi_q = pin_q_r[N_SRC];
   assign stby_q = pin_q_r[N_SRC+1];

   always_comb
   begin
      // A change counts only once the last two stages agree
      for (int b = 0; b < NP; b++)
      begin
         pin_q_nxt[b] = (sync_r[1][b] == sync_r[2][b]) ?
                        sync_r[2][b] : pin_q_r[b];
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         for (int s = 0; s < NS; s++)
         begin
            sync_r[s] <= '0;
         end
         pin_q_r <= '0;
      end
      else
      begin
         sync_r[0] <= {standby_in, nmi_req_in, src_req_in};
         for (int s = 1; s < NS; s++)
         begin
            sync_r[s] <= sync_r[s-1];
         end
         pin_q_r <= pin_q_nxt;
      end
   end

   // Selection; requests are levels, so a loser stays pending
   generate
      for (genvar g = 0; g < N_SRC; g++)
      begin : g_cand
         assign cand[g] = req_q[g] && enable_r[g] && // [R2] [R13]
                          stage1_pass(mode_r, cpu_mask_in, ctl_r[g]);
      end
   endgenerate

   always_comb
   begin
      logic [3:0] key;
      logic [3:0] best;
      logic found;
      logic [2:0] p;
      key = 4'h0;
      best = 4'h0;
      found = 1'b0;
      p = 3'h0;
      out_nxt = '0;
      // Walk downward with >= so the lowest index wins a tie [R12]
      for (int i = N_SRC - 1; i >= 0; i--)
      begin
         p = mode_r[1] ? src_prio(prio_r, i) : 3'h0; // [R8] [R10]
         unique case (mode_r)
            IMMS_MODE2: key = {p, 1'b0};
            default: key = {p, ctl_r[i]}; // [R6]
         endcase
         if (cand[i] && (!found || key >= best))
         begin
            found = 1'b1;
            best = key;
            out_nxt.src = 8'(i);
            out_nxt.prio = p;
         end
      end
      // Strictly above the CPU level, only in modes 2 and 3 [R11]
      out_nxt.valid = found && (!mode_r[1] ||
                      out_nxt.prio > cpu_mask_in.cpu_mask_level);
      nmi_nxt = nmi_q && !stby_q; // [R1]
   end

   // Bus slave: one wait cycle, then the access completes
   assign wr_go = avs_write_in && !wait_r;
   assign rd_go = avs_read_in && !wait_r;
   assign events = {nmi_nxt && !nmi_r,
                    out_nxt.valid && !out_r.valid};

   always_comb
   begin
      mode_nxt = mode_r;
      enable_nxt = enable_r;
      ctl_nxt = ctl_r;
      prio_nxt = prio_r;
      imask_nxt = imask_r;
      status_nxt = status_r;
      rdata_nxt = rdata_r;
      wait_nxt = 1'b1;
      if ((avs_read_in || avs_write_in) && wait_r)
      begin
         wait_nxt = 1'b0;
      end
      if (avs_read_in && wait_r)
      begin
         rdata_nxt = 32'h0000_0000;
         unique case (avs_address_in)
            `IMMS_OFS_SYSCTL: rdata_nxt[1:0] = mode_r;
            `IMMS_OFS_ENABLE: rdata_nxt[N_SRC-1:0] = enable_r;
            `IMMS_OFS_CTLLVL: rdata_nxt[N_SRC-1:0] = ctl_r;
            `IMMS_OFS_PRIO: rdata_nxt = prio_r;
            `IMMS_OFS_STATUS: rdata_nxt[1:0] = status_r;
            `IMMS_OFS_IMASK: rdata_nxt[1:0] = imask_r;
            `IMMS_OFS_RESULT:
            begin
               rdata_nxt[0] = out_r.valid;
               rdata_nxt[`IMMS_RES_NMI_BIT] = nmi_r;
               rdata_nxt[`IMMS_RES_SRC_LSB +: 8] = out_r.src;
               rdata_nxt[`IMMS_RES_PRIO_LSB +: 3] = out_r.prio;
            end
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      if (wr_go)
      begin
         unique case (avs_address_in)
            `IMMS_OFS_SYSCTL:
               mode_nxt = imms_mode_t'(avs_writedata_in[1:0]); // [R3]
            `IMMS_OFS_ENABLE: enable_nxt = avs_writedata_in[N_SRC-1:0];
            `IMMS_OFS_CTLLVL: ctl_nxt = avs_writedata_in[N_SRC-1:0];
            `IMMS_OFS_PRIO: prio_nxt = avs_writedata_in;
            `IMMS_OFS_IMASK: imask_nxt = avs_writedata_in[1:0];
            default: ;
         endcase
      end
      // Read clears only the bits it reported, so an event that lands
      // during the wait cycle is not lost
      if (rd_go && avs_address_in == `IMMS_OFS_STATUS)
      begin
         status_nxt = status_r & ~rdata_r[1:0];
      end
      status_nxt = status_nxt | events;
      irq_nxt = |(status_nxt & imask_nxt);
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         mode_r <= imms_mode_t'(`IMMS_RST_MODE);
         enable_r <= N_SRC'(`IMMS_RST_ENABLE);
         ctl_r <= N_SRC'(`IMMS_RST_CTLLVL);
         prio_r <= `IMMS_RST_PRIO;
         imask_r <= `IMMS_RST_IMASK;
         status_r <= 2'h0;
         rdata_r <= 32'h0000_0000;
         wait_r <= 1'b1;
         out_r <= '0;
         nmi_r <= 1'b0;
         irq_r <= 1'b0;
         ctl_d_r <= '0;
      end
      else
      begin
         mode_r <= mode_nxt;
         enable_r <= enable_nxt;
         ctl_r <= ctl_nxt;
         prio_r <= prio_nxt;
         imask_r <= imask_nxt;
         status_r <= status_nxt;
         rdata_r <= rdata_nxt;
         wait_r <= wait_nxt;
         out_r <= out_nxt; // [R14]
         nmi_r <= nmi_nxt;
         irq_r <= irq_nxt;
         ctl_d_r <= ctl_r;
      end
   end

   assign avs_readdata_out = rdata_r;
   assign avs_waitrequest_out = wait_r;
   assign irq_req_out = out_r.valid;
   assign irq_src_out = out_r.src;
   assign irq_prio_out = out_r.prio;
   assign nmi_out = nmi_r;
   assign irq_out = irq_r;

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!reset_n_in);

   chk_nmi_accept: assert property ( // [R1]
      nmi_out == $past(nmi_q && !stby_q))
      else $error("NMI output does not follow request and standby");

   chk_enable_gate: assert property ( // [R2]
      irq_req_out |-> |($past(enable_r & req_q) &
                        (N_SRC'(1) << irq_src_out[2:0])))
      else $error("Winner was not an enabled pending source");

   chk_mode0_mask: assert property ( // [R4]
      irq_req_out |-> !($past(mode_r) == IMMS_MODE0 &&
                        $past(cpu_mask_in.mask_flag)))
      else $error("Mode 0 request while mask flag set");

   chk_mode1_mask: assert property ( // [R5]
      irq_req_out && $past(mode_r) == IMMS_MODE1 &&
      $past(cpu_mask_in.mask_flag) |->
         !$past(cpu_mask_in.user_mask_bit) &&
         ctl_d_r[irq_src_out[2:0]])
      else $error("Mode 1 three-level masking violated");

   chk_ctl_first: assert property ( // [R6]
      irq_req_out && !$past(mode_r[1]) && $past(|(cand & ctl_r)) |->
         ctl_d_r[irq_src_out[2:0]])
      else $error("Control level 0 source beat a level 1 source");

   chk_level_mask: assert property ( // [R11]
      irq_req_out && $past(mode_r[1]) |->
         irq_prio_out > $past(cpu_mask_in.cpu_mask_level))
      else $error("Priority not above CPU mask level");

   chk_low_modes: assert property ( // [R10]
      !$past(mode_r[1]) |-> irq_req_out == $past(|cand) &&
                            irq_prio_out == 3'h0)
      else $error("Modes 0 and 1 must pass every candidate");

   chk_bus_answer: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=>
         !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("Bus answer not one wait cycle");

   chk_irq_level: assert property (
      irq_out == |(status_r & imask_r))
      else $error("Interrupt output not status and mask");

endmodule

// ### imms_defines.svh
`ifndef IMMS_DEFINES_SVH
`define IMMS_DEFINES_SVH

// Register byte offsets
`define IMMS_OFS_SYSCTL 8'h00
`define IMMS_OFS_ENABLE 8'h04
`define IMMS_OFS_CTLLVL 8'h08
`define IMMS_OFS_PRIO 8'h0C
`define IMMS_OFS_STATUS 8'h10
`define IMMS_OFS_IMASK 8'h14
`define IMMS_OFS_RESULT 8'h18

// Field positions
`define IMMS_BIT_EV_SEL 0
`define IMMS_BIT_EV_NMI 1
`define IMMS_PRIO_STRIDE 4
`define IMMS_RES_SRC_LSB 8
`define IMMS_RES_PRIO_LSB 16
`define IMMS_RES_NMI_BIT 1

// Reset values
`define IMMS_RST_MODE 2'h0
`define IMMS_RST_ENABLE 32'h0000_0000
`define IMMS_RST_CTLLVL 32'h0000_0000
`define IMMS_RST_PRIO 32'h0000_0000
`define IMMS_RST_IMASK 2'h0

// Pin synchroniser depth
`define IMMS_SYNC_STAGES 3

`endif

// ### imms_pkg.sv
package imms_pkg;

   typedef enum logic [1:0]
   {
      IMMS_MODE0 = 2'b00,
      IMMS_MODE1 = 2'b01,
      IMMS_MODE2 = 2'b10,
      IMMS_MODE3 = 2'b11
   } imms_mode_t;

   // Mask state presented by the CPU core
   typedef struct packed
   {
      logic mask_flag;
      logic user_mask_bit;
      logic [2:0] cpu_mask_level;
   } imms_cpu_mask_t;

   // Outcome of one selection pass
   typedef struct packed
   {
      logic valid;
      logic [7:0] src;
      logic [2:0] prio;
   } imms_sel_t;

endpackage

// ### imms_cpu_model.sv
module imms_cpu_model
   import imms_pkg::*;
(
   input wire logic clk_sys_in,
   input wire imms_cpu_mask_t set_in,
   output imms_cpu_mask_t cpu_mask_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // The core updates its flags only at a clock edge, never mid-cycle
   always_ff @(posedge clk_sys_in)
      cpu_mask_out <= set_in;
endmodule

// ### tb_top.sv
module tb_top
   import imms_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in, reset_n_in, nmi_req_in, standby_in, avs_read_in;
   logic avs_write_in, avs_waitrequest_out, irq_req_out, nmi_out, irq_out;
   logic [7:0] src_req_in, avs_address_in, irq_src_out;
   logic [31:0] avs_writedata_in, avs_readdata_out, rd;
   logic [2:0] irq_prio_out;
   imms_cpu_mask_t mask_set, cpu_mask;
   int n_errors, tests_run;

   imms_selector #(.N_SRC(8)) imms_selector_inst (.clk_sys_in, .reset_n_in,
      .src_req_in, .nmi_req_in, .standby_in, .cpu_mask_in(cpu_mask),
      .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
      .avs_readdata_out, .avs_waitrequest_out, .irq_req_out, .irq_src_out,
      .irq_prio_out, .nmi_out, .irq_out);
   imms_cpu_model imms_cpu_model_inst (.clk_sys_in, .set_in(mask_set),
      .cpu_mask_out(cpu_mask));

   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Held until the edge that sees waitrequest low; data taken there,
   // then one idle edge so the next call never re-drives a strobe
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      avs_address_in <= a;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      avs_writedata_in <= d;
      do
         @(posedge clk_sys_in);
      while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask

   task automatic cfg(input logic [1:0] m, input logic [7:0] en,
                      input logic [7:0] lvl, input logic [31:0] pr);
      bus(1'b1, 8'h00, {30'h0, m});
      bus(1'b1, 8'h04, {24'h0, en});
      bus(1'b1, 8'h08, {24'h0, lvl});
      bus(1'b1, 8'h0C, pr);
   endtask

   // Pins need five cycles to reach the outputs; six leaves margin
   task automatic sel(input logic [4:0] msk, input logic [7:0] req,
                      input logic v, input logic [7:0] s,
                      input logic [2:0] p);
      mask_set <= msk;
      src_req_in <= req;
      repeat (6) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      cmp(irq_req_out, v);
      if (v)
         cmp({irq_src_out, irq_prio_out}, {s, p});
      @(posedge clk_sys_in);
   endtask

   task automatic t_regs;
      for (int a = 0; a <= 32'h1C; a += 4)
      begin
         bus(1'b0, a[7:0], 32'h0);
         cmp(rd, 32'h0);
      end
      bus(1'b1, 8'h1C, 32'hFFFFFFFF);
      bus(1'b0, 8'h1C, 32'h0);
      cmp(rd, 32'h0);
      for (int m = 0; m < 4; m++)
      begin
         bus(1'b1, 8'h00, m);
         bus(1'b0, 8'h00, 32'h0);
         cmp(rd, m);
      end
   endtask

   task automatic t_mode01;
      cfg(2'h0, 8'h28, 8'h20, 32'h0);
      sel(5'h00, 8'h40, 1'b0, 8'h0, 3'h0);
      sel(5'h00, 8'h68, 1'b1, 8'h5, 3'h0);
      sel(5'h08, 8'h68, 1'b1, 8'h5, 3'h0);
      sel(5'h10, 8'h68, 1'b0, 8'h0, 3'h0);
      bus(1'b1, 8'h00, 32'h1);
      sel(5'h10, 8'h68, 1'b1, 8'h5, 3'h0);
      sel(5'h18, 8'h68, 1'b0, 8'h0, 3'h0);
      sel(5'h00, 8'h68, 1'b1, 8'h5, 3'h0);
      sel(5'h00, 8'h48, 1'b1, 8'h3, 3'h0);
   endtask

   task automatic t_prio;
      cfg(2'h2, 8'h0F, 8'h01, 32'h00001552);
      sel(5'h1C, 8'h0F, 1'b1, 8'h1, 3'h5);
      sel(5'h1D, 8'h0F, 1'b0, 8'h0, 3'h0);
      sel(5'h1C, 8'h0D, 1'b1, 8'h2, 3'h5);
      bus(1'b1, 8'h00, 32'h3);
      sel(5'h10, 8'h0D, 1'b1, 8'h0, 3'h2);
      sel(5'h12, 8'h0D, 1'b0, 8'h0, 3'h0);
      sel(5'h01, 8'h0D, 1'b1, 8'h2, 3'h5);
      bus(1'b1, 8'h00, 32'h1);
      sel(5'h07, 8'h0D, 1'b1, 8'h0, 3'h0);
   endtask

   task automatic t_nmi;
      bus(1'b1, 8'h00, 32'h0);
      nmi_req_in <= 1'b1;
      sel(5'h18, 8'h00, 1'b0, 8'h0, 3'h0);
      cmp(nmi_out, 1'b1);
      bus(1'b0, 8'h10, 32'h0);
      cmp(rd[1], 1'b1);
      standby_in <= 1'b1;
      sel(5'h18, 8'h00, 1'b0, 8'h0, 3'h0);
      cmp(nmi_out, 1'b0);
      standby_in <= 1'b0;
      nmi_req_in <= 1'b0;
   endtask

   task automatic t_irq;
      bus(1'b0, 8'h10, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      cmp(rd, 32'h0);
      bus(1'b1, 8'h14, 32'h1);
      cfg(2'h0, 8'h08, 8'h00, 32'h0);
      sel(5'h00, 8'h08, 1'b1, 8'h3, 3'h0);
      cmp(irq_out, 1'b1);
      bus(1'b0, 8'h18, 32'h0);
      cmp(rd, 32'h00000301);
      bus(1'b0, 8'h10, 32'h0);
      cmp(rd[0], 1'b1);
      repeat (2) @(posedge clk_sys_in);
      cmp(irq_out, 1'b0);
      bus(1'b1, 8'h14, 32'h0);
      sel(5'h00, 8'h00, 1'b0, 8'h0, 3'h0);
      sel(5'h00, 8'h08, 1'b1, 8'h3, 3'h0);
      cmp(irq_out, 1'b0);
      bus(1'b0, 8'h10, 32'h0);
      cmp(rd[0], 1'b1);
   endtask

   initial
   begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end

   initial
   begin
      #200000;
      n_errors++;
      test_done;
   end

   initial
   begin
      reset_n_in = 1'b0;
      src_req_in = 8'h00;
      nmi_req_in = 1'b0;
      standby_in = 1'b0;
      avs_address_in = 8'h00;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0;
      mask_set = 5'h00;
      n_errors = 0;
      tests_run = 0;
      repeat (6) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      @(posedge clk_sys_in);
      t_regs;
      t_mode01;
      t_prio;
      t_nmi;
      t_irq;
      test_done;
   end
endmodule
